// ### design/hri_host.sv
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module hri_host
	import hri_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	hri_bus_if.host bus,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	logic aw_got_r;
	logic w_got_r;
	logic [3:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic awready_r;
	logic wready_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic arready_r;
	logic rvalid_r;
	logic [1:0] rresp_r;
	logic [31:0] rdata_r;
	logic do_write;
	logic mux_r;
	logic chip_reset_r;
	logic start_r;
	logic refused_r;
	logic busy_r;
	logic [7:0] cmd_addr_r;
	logic [7:0] cmd_wdata_r;
	logic cmd_write_r;
	logic [7:0] rd_byte_r;
	hri_host_state_t state_r;
	logic [3:0] cnt_r;
	logic [7:0] addr_out_r;
	logic [7:0] data_out_r;
	logic data_oe_r;
	logic rd_n_r;
	logic wr_n_r;
	logic ale_r;
	logic cs_n_r;

	assign do_write = aw_got_r && w_got_r && !bvalid_r;

	// write channels taken in either order, answered once both are in
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			awaddr_r <= 4'h0;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= HRI_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && awready_r) begin
				aw_got_r <= 1'b1;
				awready_r <= 1'b0;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wready_r) begin
				w_got_r <= 1'b1;
				wready_r <= 1'b0;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (do_write) begin
				bvalid_r <= 1'b1;
				bresp_r <= (awaddr_r == HRI_HOST_CONFIG || awaddr_r == HRI_HOST_COMMAND) ?
					HRI_RESP_OKAY : HRI_RESP_SLVERR;
			end
			if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				awready_r <= 1'b1;
				wready_r <= 1'b1;
			end
		end
	end

	// controller settings and command acceptance
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			mux_r <= 1'b0;
			chip_reset_r <= 1'b0;
			start_r <= 1'b0;
			refused_r <= 1'b0;
			cmd_addr_r <= 8'h00;
			cmd_wdata_r <= 8'h00;
			cmd_write_r <= 1'b0;
		end else begin
			start_r <= 1'b0;
			if (do_write && awaddr_r == HRI_HOST_CONFIG && wstrb_r[0]) begin
				mux_r <= wdata_r[HRI_CFG_MUX_BIT];
				chip_reset_r <= wdata_r[HRI_CFG_CHIP_RESET_BIT]; // R5
			end
			if (do_write && awaddr_r == HRI_HOST_COMMAND && wstrb_r == 4'hf
					&& !busy_r && !start_r) begin
				// reserved normal addresses are refused, test space is allowed
				if (!wdata_r[7] && wdata_r[7:0] != HRI_MASTER_RESET_IDENTITY_LOAD
						&& !hri_is_rw(wdata_r[7:0]) && !hri_is_ro(wdata_r[7:0])) begin
					refused_r <= 1'b1; // R15 R16
				end else begin
					refused_r <= 1'b0;
					start_r <= 1'b1;
					cmd_addr_r <= wdata_r[7:0];
					cmd_write_r <= wdata_r[HRI_CMD_WRITE_BIT];
					// unused bits forced to zero
					cmd_wdata_r <= wdata_r[15:8] &
						(wdata_r[7] ? HRI_FULL_MASK : hri_wmask(wdata_r[7:0])); // R11
				end
			end
		end
	end

	// status read; only one read under way
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rresp_r <= HRI_RESP_OKAY;
			rdata_r <= 32'h0000_0000;
		end else if (s_axi_arvalid && arready_r) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b1;
			rresp_r <= HRI_RESP_OKAY;
			rdata_r <= 32'h0000_0000;
			case (s_axi_araddr)
				HRI_HOST_CONFIG: rdata_r <= {30'h0000_0000, chip_reset_r, mux_r};
				HRI_HOST_STATUS: rdata_r <= {15'h0000, !bus.interrupt_request_n,
					rd_byte_r, 5'h00, refused_r, cmd_write_r, busy_r || start_r};
				default: rresp_r <= HRI_RESP_SLVERR;
			endcase
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
			arready_r <= 1'b1;
		end
	end

	// pin sequencer: optional ale phase, setup, strobe, hold
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_r <= HRI_IDLE;
			cnt_r <= 4'h0;
			busy_r <= 1'b0;
			addr_out_r <= 8'h00;
			data_out_r <= 8'h00;
			data_oe_r <= 1'b0;
			rd_n_r <= 1'b1;
			wr_n_r <= 1'b1;
			ale_r <= 1'b0;
			cs_n_r <= 1'b1;
			rd_byte_r <= 8'h00;
		end else begin
			case (state_r)
				HRI_IDLE: begin
					if (start_r) begin
						busy_r <= 1'b1;
						addr_out_r <= cmd_addr_r; // R1
						if (mux_r) begin
							state_r <= HRI_LATCH;
							cnt_r <= HRI_ALE_CYCLES;
							ale_r <= 1'b1; // R22
							data_out_r <= cmd_addr_r;
							data_oe_r <= 1'b1;
						end else begin
							state_r <= HRI_SETUP;
							cs_n_r <= 1'b0; // R6
							data_out_r <= cmd_wdata_r;
							data_oe_r <= cmd_write_r;
						end
					end
				end
				HRI_LATCH: begin
					cnt_r <= cnt_r - 4'h1;
					if (cnt_r == 4'h1) begin
						state_r <= HRI_SETUP;
						ale_r <= 1'b0;
						cs_n_r <= 1'b0; // R6
						data_out_r <= cmd_wdata_r;
						data_oe_r <= cmd_write_r;
					end
				end
				HRI_SETUP: begin
					state_r <= HRI_STROBE;
					cnt_r <= HRI_STROBE_CYCLES;
					rd_n_r <= cmd_write_r; // R3
					wr_n_r <= !cmd_write_r; // R3
				end
				HRI_STROBE: begin
					cnt_r <= cnt_r - 4'h1;
					if (cnt_r == 4'h1) begin
						state_r <= HRI_HOLD;
						cnt_r <= HRI_HOLD_CYCLES;
						rd_n_r <= 1'b1;
						wr_n_r <= 1'b1;
						if (!cmd_write_r) begin
							rd_byte_r <= bus.data_bus;
						end
					end
				end
				HRI_HOLD: begin
					cnt_r <= cnt_r - 4'h1;
					if (cnt_r == 4'h1) begin
						state_r <= HRI_IDLE;
						cs_n_r <= 1'b1; // R6
						data_oe_r <= 1'b0;
						busy_r <= 1'b0;
					end
				end
				default: state_r <= HRI_IDLE;
			endcase
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;
	assign bus.addr = addr_out_r;
	assign bus.host_data = data_out_r;
	assign bus.host_data_oe = data_oe_r;
	assign bus.read_strobe_n = rd_n_r;
	assign bus.write_strobe_n = wr_n_r;
	assign bus.ale = ale_r;
	assign bus.chip_select_n = cs_n_r;
	assign bus.master_reset_n = !chip_reset_r; // R5

endmodule
`default_nettype wire

// ### design/hri_pkg.sv
package hri_pkg;

	// register map of the device
	localparam logic [7:0] HRI_MASTER_RESET_IDENTITY_LOAD = 8'h00;
	localparam logic [7:0] HRI_MASTER_CONFIGURATION = 8'h01;
	localparam logic [7:0] HRI_MASTER_INTERRUPT_STATUS = 8'h02;
	localparam logic [7:0] HRI_MASTER_MODE_CONTROL = 8'h03;
	localparam logic [7:0] HRI_MASTER_TEST = 8'h80;

	// fields of address 0x00, and the address bit that selects test registers
	localparam int HRI_SOFT_RESET_BIT = 7;
	localparam int HRI_TIP_BIT = 3;
	localparam int HRI_TEST_SELECT_BIT = 7;

	// reset values and write masks of the documented registers
	localparam logic [7:0] HRI_MASTER_CONFIGURATION_RST = 8'h71;
	localparam logic [7:0] HRI_MASTER_CONFIGURATION_MASK = 8'h7f;
	localparam logic [7:0] HRI_MASTER_MODE_CONTROL_RST = 8'h03;
	localparam logic [7:0] HRI_MASTER_MODE_CONTROL_MASK = 8'h03;
	localparam logic [7:0] HRI_FULL_MASK = 8'hff;

	// pin timing in cycles of the 100 MHz clock
	localparam logic [3:0] HRI_ALE_CYCLES = 4'h2;
	localparam logic [3:0] HRI_STROBE_CYCLES = 4'h4;
	localparam logic [3:0] HRI_HOLD_CYCLES = 4'h1;
	localparam logic [7:0] HRI_TIP_CYCLES = 8'h08;

	// host controller register offsets and fields
	localparam logic [3:0] HRI_HOST_CONFIG = 4'h0;
	localparam logic [3:0] HRI_HOST_COMMAND = 4'h4;
	localparam logic [3:0] HRI_HOST_STATUS = 4'h8;
	localparam int HRI_CFG_MUX_BIT = 0;
	localparam int HRI_CFG_CHIP_RESET_BIT = 1;
	localparam int HRI_CMD_WRITE_BIT = 16;
	localparam logic [1:0] HRI_RESP_OKAY = 2'b00;
	localparam logic [1:0] HRI_RESP_SLVERR = 2'b10;

	typedef enum logic [4:0] {
		HRI_IDLE = 5'b00001,
		HRI_LATCH = 5'b00010,
		HRI_SETUP = 5'b00100,
		HRI_STROBE = 5'b01000,
		HRI_HOLD = 5'b10000
	} hri_host_state_t;

	// normal-mode address that holds writable bits
	function automatic logic hri_is_rw(input logic [7:0] a);
		case (a)
			8'h01, 8'h03, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0a, 8'h0c, 8'h10, 8'h14,
			8'h15, 8'h18, 8'h19, 8'h20, 8'h21, 8'h30, 8'h33, 8'h3d, 8'h40, 8'h41,
			8'h45, 8'h46, 8'h48, 8'h49, 8'h50, 8'h51, 8'h52, 8'h53: hri_is_rw = 1'b1;
			default: hri_is_rw = 1'b0;
		endcase
	endfunction

	// writable address that also carries status bits
	function automatic logic hri_is_mixed(input logic [7:0] a);
		case (a)
			8'h05, 8'h06, 8'h08, 8'h18, 8'h19, 8'h30, 8'h50, 8'h51: hri_is_mixed = 1'b1;
			default: hri_is_mixed = 1'b0;
		endcase
	endfunction

	// read-only normal-mode address
	function automatic logic hri_is_ro(input logic [7:0] a);
		case (a)
			8'h02, 8'h04, 8'h11, 8'h12, 8'h13, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h1e,
			8'h1f, 8'h31, 8'h37, 8'h38, 8'h39, 8'h3a, 8'h3b, 8'h54, 8'h55: hri_is_ro = 1'b1;
			default: hri_is_ro = 1'b0;
		endcase
	endfunction

	// bits that may be stored; unused bits are zero here
	function automatic logic [7:0] hri_wmask(input logic [7:0] a);
		case (a)
			HRI_MASTER_CONFIGURATION: hri_wmask = HRI_MASTER_CONFIGURATION_MASK;
			HRI_MASTER_MODE_CONTROL: hri_wmask = HRI_MASTER_MODE_CONTROL_MASK;
			default: hri_wmask = HRI_FULL_MASK;
		endcase
	endfunction

	function automatic logic [7:0] hri_rst_val(input logic [7:0] a);
		case (a)
			HRI_MASTER_CONFIGURATION: hri_rst_val = HRI_MASTER_CONFIGURATION_RST;
			HRI_MASTER_MODE_CONTROL: hri_rst_val = HRI_MASTER_MODE_CONTROL_RST;
			default: hri_rst_val = 8'h00;
		endcase
	endfunction

endpackage

// ### design/hri_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface hri_bus_if;
	logic [7:0] addr;
	logic [7:0] host_data;
	logic host_data_oe;
	logic [7:0] dev_data;
	logic dev_data_oe;
	logic [7:0] data_bus;
	logic read_strobe_n;
	logic write_strobe_n;
	logic ale;
	logic chip_select_n;
	logic master_reset_n;
	logic interrupt_request_n;

	// shared data lines; undriven lines float high
	assign data_bus = host_data_oe ? host_data : (dev_data_oe ? dev_data : 8'hff);

	modport host (
		output addr, host_data, host_data_oe, read_strobe_n, write_strobe_n,
		output ale, chip_select_n, master_reset_n,
		input data_bus, interrupt_request_n
	);
	modport device (
		input addr, data_bus, read_strobe_n, write_strobe_n, ale, chip_select_n,
		input master_reset_n,
		output dev_data, dev_data_oe, interrupt_request_n
	);
endinterface
`default_nettype wire

// ### design/hri_device.sv
// Behaviour
// R1 - 8-bit shared data bus, separate address bus
// R2 - separate or multiplexed address/data operation
// R3 - distinct read and write strobes
// R4 - interrupt request output active low
// R5 - master chip reset input resets everything
// R6 - strobes ignored while chip select high
// R7 - address bit 7 selects test registers
// R8 - test registers separate from normal set
// R9 - writes to unused bits change nothing
// R10 - unused bits may read either level
// R11 - host writes zero to unused bits
// R12 - writable configuration bits read back
// R13 - writable bits cleared on reset unless noted
// R14 - writes to read-only bits ignored
// R15 - host writes reserved bits as designated
// R16 - host avoids reserved addresses
// R17 - address 0x00 bit 7 software reset
// R18 - address 0x00 low bits give revision
// R19 - write with reset clear loads counters
// R20 - transfer flag high until load completes
// R21 - software reset held until cleared, hardware clears
// R22 - multiplexed address captured while ale high
`timescale 1ns/1ps
`default_nettype none
module hri_device
	import hri_pkg::*;
#(
	parameter logic [2:0] DEVICE_TYPE = 3'b010, // arbitrary value
	parameter logic [2:0] REVISION = 3'b001, // arbitrary value
	parameter logic [7:0] TIP_CYCLES = HRI_TIP_CYCLES
) (
	input wire logic clock,
	input wire logic rst_n,
	hri_bus_if.device bus,
	input wire logic mux_mode,
	input wire logic [7:0] status_data,
	input wire logic [7:0] irq_sources,
	output logic [7:0] status_addr,
	output logic soft_reset_active,
	output logic load_counters,
	output logic reg_write_pulse,
	output logic [7:0] reg_write_addr,
	output logic [7:0] reg_write_data,
	output logic [7:0] master_configuration,
	output logic [7:0] master_mode_control
);

	logic hard_rst;
	logic dev_rst;
	logic soft_reset_r;
	logic rd_act;
	logic wr_act;
	logic wr_prev_r;
	logic commit;
	logic [7:0] addr_r;
	logic [7:0] read_addr_r;
	logic [7:0] sel_addr;
	logic [7:0] wdata_r;
	logic [7:0] cfg_mem [0:127];
	logic [7:0] test_r;
	logic tip_r;
	logic [7:0] tip_cnt_r;
	logic load_r;
	logic [7:0] rd_val;
	logic [7:0] dout_r;
	logic dout_oe_r;
	logic irq_n_r;
	logic wpulse_r;
	logic [7:0] waddr_r;
	logic [7:0] wdat_r;

	// pin reset or bus reset resets all; software reset spares its bit, the counter load and transfer flag, and the bus side except the interrupt request
	assign hard_rst = !rst_n || !bus.master_reset_n; // R5
	assign dev_rst = hard_rst || soft_reset_r; // R21

	// a strobe counts only with chip select low
	assign rd_act = !bus.chip_select_n && !bus.read_strobe_n; // R3 R6
	assign wr_act = !bus.chip_select_n && !bus.write_strobe_n; // R3 R6
	// write lands when the strobe ends, data then stable for a whole strobe
	assign commit = wr_prev_r && !wr_act;
	assign sel_addr = mux_mode ? addr_r : bus.addr; // R2

	// address capture: from ale in multiplexed form, else the address pins
	// kept alive in software reset, else the host could never write the bit back to zero
	always_ff @(posedge clock) begin
		if (hard_rst) begin
			addr_r <= 8'h00;
		end else if (mux_mode) begin
			if (bus.ale) begin
				addr_r <= bus.data_bus; // R22
			end
		end else if (rd_act || wr_act) begin
			addr_r <= bus.addr; // R1
		end
	end

	// write data and strobe history
	always_ff @(posedge clock) begin
		if (hard_rst) begin
			wdata_r <= 8'h00; // R21
			wr_prev_r <= 1'b0;
		end else begin
			wr_prev_r <= wr_act;
			if (wr_act) begin
				wdata_r <= bus.data_bus; // R1
			end
		end
	end

	// software reset bit; only a hardware reset or a zero write clears it
	always_ff @(posedge clock) begin
		if (hard_rst) begin
			soft_reset_r <= 1'b0; // R21
		end else if (commit && addr_r == HRI_MASTER_RESET_IDENTITY_LOAD) begin
			soft_reset_r <= wdata_r[HRI_SOFT_RESET_BIT]; // R17
		end
	end

	// normal-mode storage; read-only and reserved addresses keep nothing
	always_ff @(posedge clock) begin
		if (dev_rst) begin
			for (int i = 0; i < 128; i++) begin
				cfg_mem[i] <= hri_rst_val(8'(i)); // R13
			end
		end else if (commit && !addr_r[HRI_TEST_SELECT_BIT] && hri_is_rw(addr_r)) begin
			cfg_mem[addr_r[6:0]] <= wdata_r & hri_wmask(addr_r); // R9 R14
		end
	end

	// master test register, reached only with address bit 7 high
	always_ff @(posedge clock) begin
		if (dev_rst) begin
			test_r <= 8'h00;
		end else if (commit && addr_r == HRI_MASTER_TEST) begin
			test_r <= wdata_r; // R7 R8
		end
	end

	// counter load and transfer flag; loads even while leaving soft reset
	always_ff @(posedge clock) begin
		if (hard_rst) begin
			tip_r <= 1'b0;
			tip_cnt_r <= 8'h00;
			load_r <= 1'b0;
		end else begin
			load_r <= 1'b0;
			if (commit && addr_r == HRI_MASTER_RESET_IDENTITY_LOAD
					&& !wdata_r[HRI_SOFT_RESET_BIT]) begin
				load_r <= 1'b1; // R19
				tip_r <= 1'b1; // R20
				tip_cnt_r <= TIP_CYCLES;
			end else if (tip_r) begin
				if (tip_cnt_r == 8'h01) begin
					tip_r <= 1'b0; // R20
				end
				tip_cnt_r <= tip_cnt_r - 8'h01;
			end
		end
	end

	// read mux works from the registered address so status_data has settled
	always_comb begin
		rd_val = 8'h00;
		if (read_addr_r[HRI_TEST_SELECT_BIT]) begin
			if (read_addr_r == HRI_MASTER_TEST) begin
				rd_val = test_r; // R7 R8
			end
		end else if (read_addr_r == HRI_MASTER_RESET_IDENTITY_LOAD) begin
			rd_val = {soft_reset_r, DEVICE_TYPE, tip_r, REVISION}; // R17 R18 R20
		end else if (hri_is_rw(read_addr_r)) begin
			// stored bits read back; status bits of mixed registers ored in
			rd_val = cfg_mem[read_addr_r[6:0]] |
				(hri_is_mixed(read_addr_r) ? status_data : 8'h00); // R12
		end else if (hri_is_ro(read_addr_r)) begin
			rd_val = status_data; // R10
		end
	end

	// read path: one cycle from strobe to data on the lines
	always_ff @(posedge clock) begin
		if (hard_rst) begin
			read_addr_r <= 8'h00; // R21
			dout_r <= 8'h00;
			dout_oe_r <= 1'b0;
		end else begin
			read_addr_r <= sel_addr;
			dout_r <= rd_val;
			dout_oe_r <= rd_act; // R1 R6
		end
	end

	// interrupt request, low while any source is active
	always_ff @(posedge clock) begin
		if (dev_rst) begin
			irq_n_r <= 1'b1;
		end else begin
			irq_n_r <= ~|irq_sources; // R4
		end
	end

	// write notice so the other blocks can mirror their fields
	always_ff @(posedge clock) begin
		if (dev_rst) begin
			wpulse_r <= 1'b0;
			waddr_r <= 8'h00;
			wdat_r <= 8'h00;
		end else begin
			wpulse_r <= commit;
			if (commit) begin
				waddr_r <= addr_r;
				wdat_r <= wdata_r;
			end
		end
	end

	assign bus.dev_data = dout_r;
	assign bus.dev_data_oe = dout_oe_r;
	assign bus.interrupt_request_n = irq_n_r;
	assign status_addr = read_addr_r;
	assign soft_reset_active = soft_reset_r;
	assign load_counters = load_r;
	assign reg_write_pulse = wpulse_r;
	assign reg_write_addr = waddr_r;
	assign reg_write_data = wdat_r;
	assign master_configuration = cfg_mem[1];
	assign master_mode_control = cfg_mem[3];

endmodule
`default_nettype wire

// ### tb/hri_bus_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module hri_bus_assertions (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire logic [7:0] data_bus,
	input wire logic host_data_oe,
	input wire logic dev_data_oe,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic ale,
	input wire logic chip_select_n,
	input wire logic master_reset_n,
	input wire logic interrupt_request_n
);
	// one clock for both ends, so one default clocking and reset
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	// strobe framing as seen on the pins
	a_strobe_select: assert property (
		(!read_strobe_n || !write_strobe_n) |-> !chip_select_n) else $error("strobe without select");
	a_one_strobe: assert property (
		!read_strobe_n |-> write_strobe_n) else $error("both strobes low");
	a_read_width: assert property (
		$fell(read_strobe_n) |-> (!read_strobe_n)[*4] ##1 read_strobe_n) else $error("read width");
	a_write_width: assert property (
		$fell(write_strobe_n) |-> (!write_strobe_n)[*4] ##1 write_strobe_n) else $error("write width");
	a_select_window: assert property (
		$fell(chip_select_n) |-> (!chip_select_n)[*6] ##1 chip_select_n) else $error("select span");
	a_setup_first: assert property (
		$fell(chip_select_n) |-> (read_strobe_n && write_strobe_n) ##1
		!(read_strobe_n && write_strobe_n)) else $error("no setup cycle");
	// data line ownership; a fight here would corrupt both ends
	a_read_answer: assert property (
		$fell(read_strobe_n) |-> ##2 dev_data_oe) else $error("read not answered");
	a_no_contention: assert property (
		!(host_data_oe && dev_data_oe)) else $error("data line contention");
	a_write_data_held: assert property (
		!write_strobe_n |-> host_data_oe && $stable(data_bus)) else $error("write data moved");
	a_ale_latch: assert property (
		$rose(ale) |-> (ale && chip_select_n && host_data_oe)[*2] ##1 !ale)
		else $error("address latch shape");
	a_reset_quiet: assert property (
		!$past(master_reset_n) |-> !dev_data_oe && interrupt_request_n)
		else $error("device active in chip reset");

	c_read: cover property ($fell(read_strobe_n));
	c_write: cover property ($fell(write_strobe_n));
	c_latch: cover property ($rose(ale));
endmodule
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import hri_pkg::*;
;
	logic clock, rst_n, mux_mode, soft_reset_active, load_counters;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [7:0] status_addr, status_data, irq_sources, master_configuration, cfg2;
	logic [7:0] mode_ctl, reg_wr_addr, reg_wr_data;
	int mismatches = 0;
	int checks_done = 0;
	int load_seen = 0;
	// rows: device address, byte written, byte read back
	logic [23:0] rows [8] = '{24'h01_ff7f, 24'h03_fe02, 24'h10_a5a5, 24'h53_5a5a,
		24'h02_ff58, 24'h05_80df, 24'h81_ff00, 24'h80_c3c3};

	hri_bus_if bus ();
	hri_bus_if bus2 ();
	// status stand-in differs per address so a wrong select shows
	assign status_data = status_addr ^ 8'h5a;

	hri_host hri_host_inst (.clock, .rst_n, .bus(bus), .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	// type and revision values are arbitrary; long transfer so a poll can see it
	hri_device #(.DEVICE_TYPE(3'b101), .REVISION(3'b110), .TIP_CYCLES(8'h40))
		hri_device_inst (.clock, .rst_n,
		.bus(bus), .mux_mode, .status_data, .irq_sources, .status_addr, .soft_reset_active,
		.load_counters, .reg_write_pulse(), .reg_write_addr(reg_wr_addr),
		.reg_write_data(reg_wr_data), .master_configuration, .master_mode_control(mode_ctl));
	// second device, pins driven by hand to misuse the select
	hri_device hri_device_inst2 (.clock, .rst_n, .bus(bus2), .mux_mode(1'b0),
		.status_data(8'h00), .irq_sources(8'h00), .status_addr(), .soft_reset_active(),
		.load_counters(), .reg_write_pulse(), .reg_write_addr(), .reg_write_data(),
		.master_configuration(cfg2), .master_mode_control());
	hri_bus_assertions hri_bus_assertions_inst (.clock, .rst_n, .addr(bus.addr),
		.data_bus(bus.data_bus), .host_data_oe(bus.host_data_oe), .dev_data_oe(bus.dev_data_oe),
		.read_strobe_n(bus.read_strobe_n), .write_strobe_n(bus.write_strobe_n), .ale(bus.ale),
		.chip_select_n(bus.chip_select_n), .master_reset_n(bus.master_reset_n),
		.interrupt_request_n(bus.interrupt_request_n));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// load pulses are one cycle wide, so count them as they pass
	always @(posedge clock) begin
		if (load_counters === 1'b1) load_seen <= load_seen + 1;
	end

	task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	// address and data offered together, each released when taken
	task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clock);
			if (aw && s_axi_awready) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end while (aw || w);
		do @(posedge clock); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge clock);
	endtask

	task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clock); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge clock); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge clock);
	endtask

	// one device access through the controller, then poll until idle
	task automatic dev_acc(input logic wr, input logic [7:0] a, input logic [7:0] d,
		output logic [31:0] st);
		logic [1:0] r;
		axi_write(HRI_HOST_COMMAND, {15'h0000, wr, d, a}, r);
		st = 32'h0000_0001;
		while (st[0] !== 1'b0) axi_read(HRI_HOST_STATUS, st, r);
	endtask

	task automatic raw_write(input logic cs_n, input logic [7:0] d);
		bus2.chip_select_n <= cs_n;
		bus2.addr <= HRI_MASTER_CONFIGURATION;
		bus2.host_data <= d;
		bus2.host_data_oe <= 1'b1;
		@(posedge clock);
		bus2.write_strobe_n <= 1'b0;
		repeat (4) @(posedge clock);
		bus2.write_strobe_n <= 1'b1;
		@(posedge clock);
		bus2.chip_select_n <= 1'b1;
		bus2.host_data_oe <= 1'b0;
		repeat (3) @(posedge clock);
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// generous bound; the whole sequence needs under a thousand cycles
	initial begin
		repeat (20000) @(posedge clock);
		mismatches++;
		stop_test();
	end

	initial begin
		logic [31:0] st;
		logic [1:0] r;
		int n;
		rst_n = 1'b0;
		mux_mode = 1'b0;
		irq_sources = 8'h00;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h00_0000_0000;
		s_axi_wstrb = 4'hf;
		{bus2.addr, bus2.host_data, bus2.host_data_oe, bus2.ale} = 18'h0_0000;
		{bus2.read_strobe_n, bus2.write_strobe_n, bus2.chip_select_n} = 3'h7;
		bus2.master_reset_n = 1'b1;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		dev_acc(1'b0, HRI_MASTER_RESET_IDENTITY_LOAD, 8'h00, st);
		check("id", 8'h56, st[15:8]);
		// same rows in separate then multiplexed bus style
		for (int m = 0; m < 2; m++) begin
			axi_write(HRI_HOST_CONFIG, 32'(m), r);
			mux_mode <= m[0];
			foreach (rows[i]) begin
				dev_acc(1'b1, rows[i][23:16], rows[i][15:8], st);
				dev_acc(1'b0, rows[i][23:16], 8'h00, st);
				check("row", rows[i][7:0], st[15:8]);
			end
		end
		check("write addr", 8'h80, reg_wr_addr);
		check("write data", 8'hc3, reg_wr_data);
		$display("test rows done");
		n = load_seen;
		dev_acc(1'b1, HRI_MASTER_RESET_IDENTITY_LOAD, 8'h80, st);
		check("soft reset", 8'h01, {7'h00, soft_reset_active});
		check("no load", 8'h00, 8'(load_seen - n));
		dev_acc(1'b0, HRI_MASTER_RESET_IDENTITY_LOAD, 8'h00, st);
		check("reset bit", 8'hd6, st[15:8]);
		dev_acc(1'b0, HRI_MASTER_CONFIGURATION, 8'h00, st);
		check("cfg in reset", HRI_MASTER_CONFIGURATION_RST, st[15:8]);
		axi_write(HRI_HOST_CONFIG, 32'h0000_0002, r);
		mux_mode <= 1'b0;
		axi_write(HRI_HOST_CONFIG, 32'h0000_0000, r);
		check("hw clears", 8'h00, {7'h00, soft_reset_active});
		$display("test software reset done");
		dev_acc(1'b1, HRI_MASTER_RESET_IDENTITY_LOAD, 8'h00, st);
		check("load", 8'h01, 8'(load_seen - n));
		check("stays out", 8'h00, {7'h00, soft_reset_active});
		dev_acc(1'b0, HRI_MASTER_RESET_IDENTITY_LOAD, 8'h00, st);
		check("tip high", 8'h5e, st[15:8]);
		repeat (64) @(posedge clock);
		dev_acc(1'b0, HRI_MASTER_RESET_IDENTITY_LOAD, 8'h00, st);
		check("tip low", 8'h56, st[15:8]);
		dev_acc(1'b1, 8'h07, 8'hff, st);
		check("refused", 8'h01, {7'h00, st[2]});
		$display("test load done");
		axi_write(4'hc, 32'h0000_0001, r);
		check("bad wr", {6'h00, HRI_RESP_SLVERR}, {6'h00, r});
		axi_read(4'hc, st, r);
		check("bad rd", {6'h00, HRI_RESP_SLVERR}, {6'h00, r});
		check("bad data", 8'h00, st[7:0]);
		irq_sources <= 8'h04;
		repeat (3) @(posedge clock);
		check("irq pin", 8'h00, {7'h00, bus.interrupt_request_n});
		axi_read(HRI_HOST_STATUS, st, r);
		check("irq status", 8'h01, {7'h00, st[16]});
		irq_sources <= 8'h00;
		repeat (3) @(posedge clock);
		check("irq idle", 8'h01, {7'h00, bus.interrupt_request_n});
		$display("test bus and interrupt done");
		raw_write(1'b1, 8'h0f);
		check("cs high", HRI_MASTER_CONFIGURATION_RST, cfg2);
		raw_write(1'b0, 8'h8f);
		check("cs low", 8'h0f, cfg2);
		dev_acc(1'b1, HRI_MASTER_MODE_CONTROL, 8'h02, st);
		rst_n <= 1'b0;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		check("cfg port", HRI_MASTER_CONFIGURATION_RST, master_configuration);
		check("mode port", HRI_MASTER_MODE_CONTROL_RST, mode_ctl);
		dev_acc(1'b0, HRI_MASTER_MODE_CONTROL, 8'h00, st);
		check("mode rst", HRI_MASTER_MODE_CONTROL_RST, st[15:8]);
		check("cfg2 rst", HRI_MASTER_CONFIGURATION_RST, cfg2);
		$display("test select and reset done");
		stop_test();
	end
endmodule
`default_nettype wire
